// ==== shared/wdp_defs.vh ====
// Constants for the postscaled watchdog timer
// ==========================================================================
// Behaviour
// - Counter runs from internal RC oscillator tick
// - Enabled watchdog forces RC oscillator on
// - Base timeout period is nominally 4 ms
// - 16-bit postscaler counts base period expirations
// - Nonvolatile configuration bits select postscaler tap
// - Periods span 4 ms to 131.072 s
// - Clear or power-down instruction zeroes counts
// - Oscillator frequency field change clears counts
// - Clock failure clears counter and postscaler
// - Software enable works only when configuration disabled
`ifndef WDP_DEFS_VH
`define WDP_DEFS_VH

`define WDP_CLK_HZ 25000000
`define WDP_BASE_PERIOD_US 4000
// RC oscillator ticks in one base period, sized to the base counter width
`define WDP_BASE_CYCLES 17'h186A0
`define WDP_BASE_W 17
`define WDP_POST_W 16
`define WDP_SEL_W 4
`define WDP_SEL_MAX 4'hF
`define WDP_FREQ_W 3
`define WDP_FREQ_HI 6
`define WDP_FREQ_LO 4

`endif

// ==== rtl/wdp_watchdog.v ====
// Postscaled watchdog timer, counting internal RC oscillator ticks
`timescale 1ns/1ps
`default_nettype none
`include "wdp_defs.vh"

module wdp_watchdog #(
  parameter [`WDP_BASE_W-1:0] BASE_CYCLES = `WDP_BASE_CYCLES
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire RC_TICK,
  input wire CFG_WDT_EN,
  input wire [`WDP_SEL_W-1:0] CFG_POST_SEL,
  input wire SW_WDT_EN,
  input wire CLR_WDT_INSTR,
  input wire SLEEP_INSTR,
  input wire IN_POWER_DOWN,
  input wire [`WDP_FREQ_W-1:0] OSC_FREQ_SEL,
  input wire CLOCK_FAIL,
  output reg RC_OSC_EN,
  output reg WDT_ACTIVE,
  output reg WDT_RESET,
  output reg WDT_WAKE,
  output reg [`WDP_POST_W-1:0] POST_COUNT
);

  // ========================================================================
  // Tick input synchroniser
  reg tick_s1_r;
  reg tick_s2_r;
  reg tick_s3_r;
  reg tick_lvl_r;
  wire tick_nxt;
  wire tick_rise;

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_s3_r <= 1'b0;
      tick_lvl_r <= 1'b0;
    end else begin
      tick_s1_r <= RC_TICK;
      tick_s2_r <= tick_s1_r;
      tick_s3_r <= tick_s2_r;
      tick_lvl_r <= tick_nxt;
    end
  end

  assign tick_nxt = (tick_s2_r == tick_s3_r) ? tick_s3_r : tick_lvl_r;
  assign tick_rise = tick_nxt & ~tick_lvl_r;

  // ========================================================================
  // Enable and clear sources
  reg [`WDP_FREQ_W-1:0] freq_r;
  reg freq_valid_r;
  wire enable;
  wire freq_change;
  wire clear_all;

  assign enable = CFG_WDT_EN | SW_WDT_EN;
  assign freq_change = freq_valid_r & (OSC_FREQ_SEL != freq_r);
  assign clear_all = CLR_WDT_INSTR | SLEEP_INSTR | freq_change | CLOCK_FAIL | ~enable;

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      freq_r <= {`WDP_FREQ_W{1'b0}};
      freq_valid_r <= 1'b0;
    end else begin
      freq_r <= OSC_FREQ_SEL;
      freq_valid_r <= 1'b1;
    end
  end

  // ========================================================================
  // Base counter and postscaler
  reg [`WDP_BASE_W-1:0] base_r;
  reg [`WDP_POST_W-1:0] post_r;
  reg [`WDP_POST_W-1:0] post_nxt;
  reg [`WDP_BASE_W-1:0] base_nxt;
  wire base_exp;
  wire [`WDP_POST_W:0] post_sum;
  wire [`WDP_POST_W:0] carry;
  wire timeout;

  assign base_exp = enable & tick_rise & (base_r == BASE_CYCLES - 1'b1);
  assign post_sum = {1'b0, post_r} + {{`WDP_POST_W{1'b0}}, 1'b1};

  // Carry out of each stage; a tap fires when all lower stages roll over
  assign carry[0] = base_exp;
  genvar gi;
  generate
    for (gi = 0; gi < `WDP_POST_W; gi = gi + 1) begin : g_carry
      assign carry[gi+1] = carry[gi] & post_r[gi];
    end
  endgenerate

  assign timeout = enable & ~clear_all & carry[CFG_POST_SEL];

  always @* begin
    base_nxt = base_r;
    post_nxt = post_r;
    if (clear_all || timeout) begin
      base_nxt = {`WDP_BASE_W{1'b0}};
      post_nxt = {`WDP_POST_W{1'b0}};
    end else if (tick_rise) begin
      if (base_exp) begin
        base_nxt = {`WDP_BASE_W{1'b0}};
        post_nxt = post_sum[`WDP_POST_W-1:0];
      end else begin
        base_nxt = base_r + 1'b1;
      end
    end
  end

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      base_r <= {`WDP_BASE_W{1'b0}};
      post_r <= {`WDP_POST_W{1'b0}};
    end else begin
      base_r <= base_nxt;
      post_r <= post_nxt;
    end
  end

  // ========================================================================
  // Registered outputs
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RC_OSC_EN <= 1'b0;
      WDT_ACTIVE <= 1'b0;
      WDT_RESET <= 1'b0;
      WDT_WAKE <= 1'b0;
      POST_COUNT <= {`WDP_POST_W{1'b0}};
    end else begin
      RC_OSC_EN <= enable;
      WDT_ACTIVE <= enable;
      WDT_RESET <= timeout & ~IN_POWER_DOWN;
      WDT_WAKE <= timeout & IN_POWER_DOWN;
      POST_COUNT <= post_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== dv/wdp_watchdog_properties.sv ====
// Watchdog port checks
`timescale 1ns/1ps
`default_nettype none
module wdp_watchdog_properties (
  input wire logic SYS_CLK, RST_B, CFG_WDT_EN, SW_WDT_EN, CLR_WDT_INSTR, SLEEP_INSTR,
  input wire logic IN_POWER_DOWN, CLOCK_FAIL, RC_OSC_EN, WDT_ACTIVE, WDT_RESET, WDT_WAKE,
  input wire logic [3:0] CFG_POST_SEL,
  input wire logic [2:0] OSC_FREQ_SEL,
  input wire logic [15:0] POST_COUNT);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  wire en = CFG_WDT_EN | SW_WDT_EN;
  wire p = WDT_RESET | WDT_WAKE;
  sequence s_clr; CLR_WDT_INSTR | SLEEP_INSTR | CLOCK_FAIL | !en; endsequence
  sequence s_zero; POST_COUNT == 16'h0 && !p; endsequence
  chk_clear_zero: assert property (s_clr |=> s_zero) else $error("bad");
  chk_freq_clear: assert property ($changed(OSC_FREQ_SEL) |=> s_zero) else $error("bad");
  chk_osc_en: assert property (RC_OSC_EN == $past(en)) else $error("bad");
  chk_active_osc: assert property (WDT_ACTIVE == RC_OSC_EN) else $error("bad");
  chk_post_step: assert property ($changed(POST_COUNT) |->
    POST_COUNT == $past(POST_COUNT) + 16'h1 || POST_COUNT == 16'h0) else $error("bad");
  chk_tap_bound: assert property (POST_COUNT < (17'h1 << CFG_POST_SEL)) else $error("bad");
  chk_pulse_once: assert property (p |=> !p) else $error("bad");
  chk_wake_mode: assert property (p |-> WDT_WAKE == $past(IN_POWER_DOWN) &&
    WDT_RESET != WDT_WAKE && POST_COUNT == 16'h0) else $error("bad");
endmodule
bind wdp_watchdog wdp_watchdog_properties u_chk (.*);
`default_nettype wire

// ==== dv/watchdog_timer_postscaled_tb.sv ====
// Watchdog bench
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_postscaled_tb;
  reg c = 0, r = 0, t = 0, g = 0, w = 0, x = 0, y = 0, d = 0, f = 0;
  reg [3:0] n = 4'h0;
  reg [2:0] q = 3'h0;
  wire o, a, rs, wk;
  wire [15:0] pc;
  integer mismatches = 0, samples_checked = 0, i, k, s;
  wdp_watchdog #(.BASE_CYCLES(17'h2)) u_dut (.SYS_CLK(c), .RST_B(r), .RC_TICK(t), .CFG_WDT_EN(g),
    .CFG_POST_SEL(n), .SW_WDT_EN(w), .CLR_WDT_INSTR(x), .SLEEP_INSTR(y), .IN_POWER_DOWN(d),
    .OSC_FREQ_SEL(q), .CLOCK_FAIL(f), .RC_OSC_EN(o), .WDT_ACTIVE(a), .WDT_RESET(rs),
    .WDT_WAKE(wk), .POST_COUNT(pc));
  initial forever #20 c = ~c;
  task print_verdict;
    begin
      if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] v, input [15:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (v !== e) begin
        mismatches = mismatches + 1;
        $display("Error %0t: %h %h", $time, v, e);
      end
    end
  endtask
  task tk(input integer m);
    begin
      s = 0;
      for (i = 0; i < m * 8; i = i + 1) begin
        @(posedge c);
        s = s + rs + 16 * wk;
        t <= i % 8 < 4;
      end
    end
  endtask
  task t_period(input [3:0] m, input p, input e);
    begin
      @(posedge c) {g, w} <= 2'h0;
      @(posedge c) {n, d} <= {m, p};
      @(posedge c) {g, w} <= {e, !e};
      tk((2 << m) - 1);
      chk(s, 0);
      chk(pc, (16'h1 << m) - 16'h1);
      tk(1);
      chk(s, p ? 16 : 1);
      chk(pc, 16'h0);
      chk({o, a}, 3);
    end
  endtask
  task t_clear(input integer z);
    begin
      t_period(4'h1, 1'b0, 1'b1);
      tk(1);
      @(posedge c) {x, y, f} <= {z == 0, z == 1, z == 3};
      q <= q + {2'h0, z == 2};
      @(posedge c) {x, y, f} <= 3'h0;
      tk(3);
      chk(s, 0);
    end
  endtask
  task t_off;
    begin
      @(posedge c) {g, w} <= 2'h0;
      tk(5);
      chk(s + o + a, 0);
    end
  endtask
  initial begin
    repeat (16) @(posedge c);
    r <= 1;
    for (k = 0; k < 4; k = k + 1) t_period(k[3:0], k[0], k < 2);
    for (k = 0; k < 4; k = k + 1) t_clear(k);
    t_off;
    print_verdict;
  end
endmodule
`default_nettype wire
